//--- hdl/fcd_defines.svh
// fcd register offsets, field positions and reset values
// assumes a single slave decoding the low address bits
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH
`define FCD_AW 12
`define FCD_OFS_FRONT 12'h000
`define FCD_OFS_SIGNAL 12'h004
`define FCD_OFS_OUTPUT 12'h008
`define FCD_OFS_STATUS 12'h00c
`define FCD_LOCK_BIT 15
`define FCD_MOD_HI 7
`define FCD_MOD_LO 6
`define FCD_RATE_HI 5
`define FCD_RATE_LO 4
`define FCD_MEAS_HI 3
`define FCD_MEAS_LO 0
`define FCD_ST_LOCK 0
`define FCD_ST_VALID 1
`define FCD_ST_REFUSED 2
`define FCD_RST_FRONT 16'h0000
`define FCD_RST_SIGNAL 16'h0000
`define FCD_RST_OUTPUT 16'h0000
`define FCD_RATE_BAD 2'h3
`define FCD_MEAS_LAST 4'h9
`endif

//--- hdl/fcd_pkg.sv
// fcd types: decoded front-end settings and bus access carrier
// assumes nothing beyond the defines header
package fcd_pkg;
    typedef enum logic [1:0] {RNG_360, RNG_90, RNG_120, RNG_180} fcd_range_t;
    typedef enum logic [1:0] {RATE_2K, RATE_4K, RATE_8K, RATE_NONE} fcd_rate_t;
    typedef enum logic [3:0] {
        SET_NONE, SET_ALIGNED, SET_STRAY_B, SET_STRAY_A, SET_CENTRE,
        SET_ROT_180, SET_ROT_360, SET_3D_ATAN, SET_3D_STICK
    } fcd_setup_t;
    typedef enum logic [3:0] {
        SRC_NONE, SRC_X1, SRC_Y1, SRC_Z1, SRC_Z2, SRC_Z4, SRC_Z6,
        SRC_X4_M_X1, SRC_Y4_M_Y1, SRC_X1_P_X4, SRC_Y1_P_Y4,
        SRC_Z1_P_Z4, SRC_Z2_P_Z5, SRC_Z3_P_Z6
    } fcd_src_t;
    typedef struct packed {
        fcd_range_t range;
        fcd_rate_t rate;
        fcd_setup_t setup;
        fcd_src_t ch1;
        fcd_src_t ch2;
        fcd_src_t ch3;
        logic [1:0] chans;
        logic pix_aligned;
        logic valid;
    } fcd_decode_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
    } fcd_acc_t;
endpackage : fcd_pkg

//--- hdl/fcd_ahb_slave.sv
// fcd ahb-lite front: address phase view and registered data phase
// assumes word-only single transfers and one slave on the bus
`timescale 1ns/100ps
module fcd_ahb_slave (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // address phase
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr,
    input wire logic hwrite,
    input wire logic hready,
    // decoded access
    output fcd_pkg::fcd_acc_t ap,
    output fcd_pkg::fcd_acc_t dp
);
    import fcd_pkg::*;
    fcd_acc_t dp_reg, dp_next;
    logic take;

    always_comb begin
        // nonseq or seq with the bus ready starts a transfer
        take = hsel && htrans[1] && hready;
        ap.wr = take && hwrite;
        ap.rd = take && !hwrite;
        ap.addr = haddr[11:0];
        dp_next = hready ? ap : dp_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_reg <= '0;
        end else begin
            dp_reg <= dp_next;
        end
    end

    assign dp = dp_reg;
endmodule : fcd_ahb_slave

//--- hdl/fcd_setup_decode.sv
// fcd front-end word decoder: range, rate, setup and channel sources
// assumes a stable 16-bit word; purely combinational
`timescale 1ns/100ps
`include "fcd_defines.svh"
module fcd_setup_decode (
    // setup word
    input wire logic [15:0] word,
    // decoded view
    output fcd_pkg::fcd_decode_t dec
);
    import fcd_pkg::*;
    logic [3:0] meas;

    always_comb begin
        meas = word[`FCD_MEAS_HI:`FCD_MEAS_LO];
        dec = '0;
        dec.range = fcd_range_t'(word[`FCD_MOD_HI:`FCD_MOD_LO]); // RULE_03
        dec.rate = fcd_rate_t'(word[`FCD_RATE_HI:`FCD_RATE_LO]); // RULE_04
        dec.chans = 2'h2;
        case (meas)
            4'h0, 4'h1, 4'h2: begin // RULE_05
                dec.setup = SET_ALIGNED;
                {dec.ch1, dec.ch2} = {SRC_X1, SRC_Y1};
                dec.pix_aligned = 1'b1; // RULE_11
            end
            4'h3: begin // RULE_06
                dec.setup = SET_STRAY_B;
                {dec.ch1, dec.ch2} = {SRC_Z4, SRC_X4_M_X1};
            end
            4'h4: begin // RULE_06
                dec.setup = SET_STRAY_A;
                {dec.ch1, dec.ch2} = {SRC_X4_M_X1, SRC_Y4_M_Y1};
            end
            4'h5: begin // RULE_07
                dec.setup = SET_CENTRE;
                {dec.ch1, dec.ch2} = {SRC_X1_P_X4, SRC_Y1_P_Y4};
            end
            4'h6: begin // RULE_08
                dec.setup = SET_ROT_180;
                {dec.ch1, dec.ch2} = {SRC_Z1_P_Z4, SRC_Z2_P_Z5};
                dec.ch3 = SRC_Z3_P_Z6;
            end
            4'h7: begin // RULE_08
                dec.setup = SET_ROT_360;
                {dec.ch1, dec.ch2, dec.ch3} = {SRC_Z1, SRC_Z6, SRC_Z2};
            end
            4'h8, 4'h9: begin // RULE_09
                dec.setup = meas[0] ? SET_3D_STICK : SET_3D_ATAN;
                {dec.ch1, dec.ch2, dec.ch3} = {SRC_Z1, SRC_X1, SRC_Y1};
                dec.chans = 2'h3;
                dec.pix_aligned = 1'b1; // RULE_11
            end
            default: begin
                dec.setup = SET_NONE;
                dec.chans = 2'h0;
            end
        endcase
        dec.valid = (dec.setup != SET_NONE) && (dec.rate != RATE_NONE);
    end
endmodule : fcd_setup_decode

//--- hdl/fcd_top.sv
// fcd top: customer configuration registers behind an ahb-lite slave
// assumes one master, word transfers, hready fed back from hreadyout
//
// Overview of operation
// (RULE_01) Front-end, signal path and output setup are 16-bit registers.
// (RULE_02) Bit 15 of the front-end word is the lock flag, 1 meaning locked.
// (RULE_03) Bits 7:6 pick 360, modulo 90, modulo 120 or modulo 180 degrees.
// (RULE_04) Bits 5:4 pick 2, 4 or 8 kSps; code 11 is not to be written.
// (RULE_05) Codes 0000 to 0010 all pick the aligned two-channel planar setup.
// (RULE_06) Codes 0011 and 0100 pick the two stray-field planar variants.
// (RULE_07) Code 0101 picks the virtual centred pixel planar setup.
// (RULE_08) Codes 0110 and 0111 pick 180 and 360 degree rotary setups.
// (RULE_09) Codes 1000 and 1001 pick 3D with arctangent or joystick.
// (RULE_10) Software never writes the reserved codes 1010 to 1111.
// (RULE_11) Footnoted setups use pixel 1 on die 1 and pixel 2 on die 2.
// (RULE_12) Software keeps the noise filter cut-off at most half the rate.
// (RULE_13) While locked, writes to the configuration registers are refused.
// (RULE_14) Software writes zero to front-end bits 14 to 8.
`timescale 1ns/100ps
`include "fcd_defines.svh"
module fcd_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // decoded front-end settings
    output fcd_pkg::fcd_decode_t cfg,
    output logic cfg_locked,
    // raw words for the signal path and output stages
    output logic [15:0] signal_path_setup,
    output logic [15:0] output_setup
);
    import fcd_pkg::*;

    fcd_acc_t ap;
    fcd_acc_t dp;
    fcd_decode_t dec_next;
    fcd_decode_t dec_reg;

    logic [15:0] frontend_setup_reg, frontend_setup_next;
    logic [15:0] signal_path_reg, signal_path_next;
    logic [15:0] output_setup_reg, output_setup_next;
    logic refused_reg, refused_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic hreadyout_reg;
    logic hresp_reg;
    logic locked;
    logic cfg_hit;
    logic refuse;
    logic refused_clr;
    logic [2:0] status_next;

    // bus front
    fcd_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .htrans(htrans),
        .haddr(haddr),
        .hwrite(hwrite),
        .hready(hready),
        .ap(ap),
        .dp(dp)
    );

    // decode of the word that stands after this cycle
    fcd_setup_decode u_decode (
        .word(frontend_setup_next),
        .dec(dec_next)
    );

    // register writes, applied in the data phase
    always_comb begin
        locked = frontend_setup_reg[`FCD_LOCK_BIT]; // RULE_02
        cfg_hit = dp.wr && (dp.addr == `FCD_OFS_FRONT ||
            dp.addr == `FCD_OFS_SIGNAL || dp.addr == `FCD_OFS_OUTPUT);
        refuse = cfg_hit && locked; // RULE_13
        frontend_setup_next = frontend_setup_reg;
        signal_path_next = signal_path_reg;
        output_setup_next = output_setup_reg;
        if (dp.wr && !locked) begin
            case (dp.addr)
                `FCD_OFS_FRONT: begin
                    frontend_setup_next = hwdata[15:0]; // RULE_01
                end
                `FCD_OFS_SIGNAL: begin
                    signal_path_next = hwdata[15:0]; // RULE_01
                end
                `FCD_OFS_OUTPUT: begin
                    output_setup_next = hwdata[15:0]; // RULE_01
                end
                default: begin
                    frontend_setup_next = frontend_setup_reg;
                end
            endcase
        end
    end

    // refused-write flag: write one to clear, a new refusal wins
    always_comb begin
        refused_clr = dp.wr && dp.addr == `FCD_OFS_STATUS &&
            hwdata[`FCD_ST_REFUSED];
        refused_next = refused_reg;
        if (refused_clr) begin
            refused_next = 1'b0;
        end
        if (refuse) begin
            refused_next = 1'b1; // RULE_13
        end
    end

    // read data from next values so a write just before is seen
    always_comb begin
        status_next = 3'h0;
        status_next[`FCD_ST_LOCK] = frontend_setup_next[`FCD_LOCK_BIT];
        status_next[`FCD_ST_VALID] = dec_next.valid;
        status_next[`FCD_ST_REFUSED] = refused_next;
        hrdata_next = hrdata_reg;
        if (ap.rd) begin
            case (ap.addr)
                `FCD_OFS_FRONT: begin
                    hrdata_next = {16'h0000, frontend_setup_next};
                end
                `FCD_OFS_SIGNAL: begin
                    hrdata_next = {16'h0000, signal_path_next};
                end
                `FCD_OFS_OUTPUT: begin
                    hrdata_next = {16'h0000, output_setup_next};
                end
                `FCD_OFS_STATUS: begin
                    hrdata_next = {29'h0000000, status_next};
                end
                default: begin
                    hrdata_next = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frontend_setup_reg <= `FCD_RST_FRONT;
            signal_path_reg <= `FCD_RST_SIGNAL;
            output_setup_reg <= `FCD_RST_OUTPUT;
            refused_reg <= 1'b0;
            hrdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
            dec_reg <= '0;
        end else begin
            frontend_setup_reg <= frontend_setup_next;
            signal_path_reg <= signal_path_next;
            output_setup_reg <= output_setup_next;
            refused_reg <= refused_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
            dec_reg <= dec_next;
        end
    end

    // zero-wait slave, always okay
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;
    assign cfg = dec_reg;
    assign cfg_locked = frontend_setup_reg[`FCD_LOCK_BIT];
    assign signal_path_setup = signal_path_reg;
    assign output_setup = output_setup_reg;

    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    cfg_word_store_a: assert property ( // RULE_01
        dp.wr && dp.addr == `FCD_OFS_SIGNAL && !locked
        |=> signal_path_setup == $past(hwdata[15:0]))
        else $error("signal path word not stored");

    lock_flag_out_a: assert property ( // RULE_02
        dp.wr && dp.addr == `FCD_OFS_FRONT && !locked &&
        hwdata[`FCD_LOCK_BIT]
        |=> cfg_locked ##1 cfg_locked)
        else $error("lock flag not raised by write");

    wrap_range_a: assert property ( // RULE_03
        cfg.range == fcd_range_t'(frontend_setup_reg[7:6]) &&
        (frontend_setup_reg[7:6] == 2'h1 -> cfg.range == RNG_90) &&
        (frontend_setup_reg[7:6] == 2'h3 -> cfg.range == RNG_180))
        else $error("wrap range mismatch");

    sample_rate_a: assert property ( // RULE_04
        (frontend_setup_reg[5:4] == 2'h2 -> cfg.rate == RATE_8K) &&
        (frontend_setup_reg[5:4] == 2'h0 -> cfg.rate == RATE_2K) &&
        (frontend_setup_reg[5:4] == `FCD_RATE_BAD -> !cfg.valid))
        else $error("sample rate mismatch");

    aligned_setup_a: assert property ( // RULE_05
        $past(hresetn) && frontend_setup_reg[3:0] <= 4'h2
        |-> cfg.setup == SET_ALIGNED && cfg.chans == 2'h2 &&
            cfg.ch3 == SRC_NONE)
        else $error("aligned setup not selected");

    stray_planar_a: assert property ( // RULE_06
        (frontend_setup_reg[3:0] == 4'h3 -> cfg.setup == SET_STRAY_B) &&
        (frontend_setup_reg[3:0] == 4'h4 -> cfg.setup == SET_STRAY_A &&
            cfg.ch2 == SRC_Y4_M_Y1))
        else $error("stray planar variant mismatch");

    centre_pixel_a: assert property ( // RULE_07
        frontend_setup_reg[3:0] == 4'h5
        |-> cfg.setup == SET_CENTRE && cfg.ch1 == SRC_X1_P_X4 &&
            cfg.ch2 == SRC_Y1_P_Y4)
        else $error("centred pixel setup mismatch");

    rotary_setup_a: assert property ( // RULE_08
        (frontend_setup_reg[3:0] == 4'h6 -> cfg.setup == SET_ROT_180 &&
            cfg.ch3 == SRC_Z3_P_Z6) &&
        (frontend_setup_reg[3:0] == 4'h7 -> cfg.setup == SET_ROT_360))
        else $error("rotary setup mismatch");

    spatial_setup_a: assert property ( // RULE_09
        frontend_setup_reg[3:1] == 3'h4
        |-> cfg.chans == 2'h3 && (frontend_setup_reg[0] ?
            cfg.setup == SET_3D_STICK : cfg.setup == SET_3D_ATAN))
        else $error("3d setup mismatch");

    pixel_align_a: assert property ( // RULE_11
        cfg.pix_aligned
        |-> cfg.ch1 inside {SRC_X1, SRC_Z1} &&
            cfg.ch2 inside {SRC_Y1, SRC_X1} &&
            cfg.ch3 inside {SRC_NONE, SRC_Y1})
        else $error("pixel alignment broken");

    lock_refuse_a: assert property ( // RULE_13
        locked && dp.wr && dp.addr == `FCD_OFS_FRONT
        |=> $stable(frontend_setup_reg) && refused_reg)
        else $error("write taken while locked");

    // stored words, read-back, lock, decode fields and refusals
    front_word_store_a: assert property ( // RULE_01
        dp.wr && dp.addr == `FCD_OFS_FRONT && !locked
        |=> frontend_setup_reg == $past(hwdata[15:0]))
        else $error("front-end word not stored");

    output_word_store_a: assert property ( // RULE_01
        dp.wr && dp.addr == `FCD_OFS_OUTPUT && !locked
        |=> output_setup == $past(hwdata[15:0]))
        else $error("output word not stored");

    upper_read_zero_a: assert property ( // RULE_01
        ap.rd |=> hrdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    front_read_back_a: assert property ( // RULE_01
        ap.rd && ap.addr == `FCD_OFS_FRONT
        |=> hrdata == {16'h0000, $past(frontend_setup_next)})
        else $error("front-end read data mismatch");

    signal_read_back_a: assert property ( // RULE_01
        ap.rd && ap.addr == `FCD_OFS_SIGNAL
        |=> hrdata == {16'h0000, $past(signal_path_next)})
        else $error("signal path read data mismatch");

    output_read_back_a: assert property ( // RULE_01
        ap.rd && ap.addr == `FCD_OFS_OUTPUT
        |=> hrdata == {16'h0000, $past(output_setup_next)})
        else $error("output read data mismatch");

    lock_sticky_a: assert property ( // RULE_02
        cfg_locked |=> cfg_locked)
        else $error("lock flag dropped without reset");

    wrap_120_a: assert property ( // RULE_03
        frontend_setup_reg[7:6] == 2'h2 |-> cfg.range == RNG_120)
        else $error("modulo 120 range mismatch");

    rate_4k_a: assert property ( // RULE_04
        frontend_setup_reg[5:4] == 2'h1 |-> cfg.rate == RATE_4K)
        else $error("4 ksps rate mismatch");

    setup_valid_a: assert property ( // RULE_04
        $past(hresetn)
        |-> cfg.valid == (frontend_setup_reg[5:4] != `FCD_RATE_BAD &&
            frontend_setup_reg[3:0] <= `FCD_MEAS_LAST))
        else $error("valid flag mismatch");

    aligned_chan_a: assert property ( // RULE_05
        $past(hresetn) && frontend_setup_reg[3:0] <= 4'h2
        |-> cfg.ch1 == SRC_X1 && cfg.ch2 == SRC_Y1 && cfg.pix_aligned)
        else $error("aligned channel sources mismatch");

    stray_chan_a: assert property ( // RULE_06
        (frontend_setup_reg[3:0] == 4'h3 -> cfg.ch1 == SRC_Z4 &&
            cfg.ch2 == SRC_X4_M_X1 && cfg.ch3 == SRC_NONE) &&
        (frontend_setup_reg[3:0] == 4'h4 -> cfg.ch1 == SRC_X4_M_X1 &&
            cfg.ch3 == SRC_NONE))
        else $error("stray planar sources mismatch");

    centre_flags_a: assert property ( // RULE_07
        frontend_setup_reg[3:0] == 4'h5
        |-> cfg.ch3 == SRC_NONE && cfg.chans == 2'h2 && !cfg.pix_aligned)
        else $error("centred pixel flags mismatch");

    rotary_chan_a: assert property ( // RULE_08
        (frontend_setup_reg[3:0] == 4'h6 -> cfg.ch1 == SRC_Z1_P_Z4 &&
            cfg.ch2 == SRC_Z2_P_Z5) &&
        (frontend_setup_reg[3:0] == 4'h7 -> cfg.ch1 == SRC_Z1 &&
            cfg.ch2 == SRC_Z6 && cfg.ch3 == SRC_Z2))
        else $error("rotary sources mismatch");

    spatial_chan_a: assert property ( // RULE_09
        frontend_setup_reg[3:1] == 3'h4
        |-> cfg.ch1 == SRC_Z1 && cfg.ch2 == SRC_X1 && cfg.ch3 == SRC_Y1)
        else $error("3d sources mismatch");

    pixel_modes_a: assert property ( // RULE_11
        $past(hresetn)
        |-> cfg.pix_aligned == (frontend_setup_reg[3:0] <= 4'h2 ||
            frontend_setup_reg[3:1] == 3'h4))
        else $error("pixel alignment flag mismatch");

    signal_refuse_a: assert property ( // RULE_13
        locked && dp.wr && dp.addr == `FCD_OFS_SIGNAL
        |=> $stable(signal_path_setup) && refused_reg)
        else $error("signal path write taken while locked");

    output_refuse_a: assert property ( // RULE_13
        locked && dp.wr && dp.addr == `FCD_OFS_OUTPUT
        |=> $stable(output_setup) && refused_reg)
        else $error("output write taken while locked");

    refused_clear_a: assert property ( // RULE_13
        refused_clr && !refuse |=> !refused_reg)
        else $error("refused flag not cleared");
endmodule : fcd_top

//--- tb/fcd_tb.sv
// fcd testbench: ahb-lite master tasks, decode table, lock and reset checks
// assumes fcd_pkg and fcd_top compiled first, hready fed back from hreadyout
`timescale 1ns/100ps
`include "fcd_defines.svh"
module tb;
    import fcd_pkg::*;
    typedef struct packed {
        logic [15:0] w;
        fcd_setup_t s;
        fcd_src_t c1;
        fcd_src_t c2;
        fcd_src_t c3;
        logic [1:0] n;
        logic p;
    } fcd_row_t;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    fcd_decode_t cfg;
    logic cfg_locked;
    logic [15:0] signal_path_setup;
    logic [15:0] output_setup;
    int fail_count = 0;
    int n_tests = 0;
    fcd_row_t rows [14];
    logic [31:0] q;
    fcd_decode_t e;
    assign hready = hreadyout;
    fcd_top DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .haddr(haddr),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg(cfg),
        .cfg_locked(cfg_locked), .signal_path_setup(signal_path_setup),
        .output_setup(output_setup)
    );
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    task chk32(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk32
    task chk_dec(input fcd_decode_t ex);
        n_tests++;
        if (cfg !== ex) begin
            fail_count++;
            $display("ERROR cfg expected %h seen %h", ex, cfg);
        end
    endtask : chk_dec
    // bounded wait for hready sampled high at a rising edge
    task wait_rdy;
        int i;
        i = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            i++;
            if (i > 40) begin
                fail_count++;
                $display("ERROR hready expected 1 seen %b", hready);
                finish_test();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
             output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
        @(negedge hclk);
    endtask : wr
    task rd(input logic [31:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask : rd
    function automatic fcd_decode_t exp_row(fcd_row_t r);
        fcd_decode_t e;
        e.range = fcd_range_t'(r.w[7:6]);
        e.rate = fcd_rate_t'(r.w[5:4]);
        e.setup = r.s;
        e.ch1 = r.c1;
        e.ch2 = r.c2;
        e.ch3 = r.c3;
        e.chans = r.n;
        e.pix_aligned = r.p;
        e.valid = (r.w[5:4] != 2'h3) && (r.w[3:0] <= 4'h9);
        return e;
    endfunction : exp_row
    initial begin
        rows[0] = '{16'h0000, SET_ALIGNED, SRC_X1, SRC_Y1, SRC_NONE, 2'h2, 1'b1};
        rows[1] = '{16'h0041, SET_ALIGNED, SRC_X1, SRC_Y1, SRC_NONE, 2'h2, 1'b1};
        rows[2] = '{16'h0092, SET_ALIGNED, SRC_X1, SRC_Y1, SRC_NONE, 2'h2, 1'b1};
        rows[3] = '{16'h00d3, SET_STRAY_B, SRC_Z4, SRC_X4_M_X1, SRC_NONE, 2'h2, 1'b0};
        rows[4] = '{16'h0024, SET_STRAY_A, SRC_X4_M_X1, SRC_Y4_M_Y1, SRC_NONE, 2'h2, 1'b0};
        rows[5] = '{16'h0005, SET_CENTRE, SRC_X1_P_X4, SRC_Y1_P_Y4, SRC_NONE, 2'h2, 1'b0};
        rows[6] = '{16'h0056, SET_ROT_180, SRC_Z1_P_Z4, SRC_Z2_P_Z5, SRC_Z3_P_Z6, 2'h2, 1'b0};
        rows[7] = '{16'h0067, SET_ROT_360, SRC_Z1, SRC_Z6, SRC_Z2, 2'h2, 1'b0};
        rows[8] = '{16'h00a8, SET_3D_ATAN, SRC_Z1, SRC_X1, SRC_Y1, 2'h3, 1'b1};
        rows[9] = '{16'h00e9, SET_3D_STICK, SRC_Z1, SRC_X1, SRC_Y1, 2'h3, 1'b1};
        rows[10] = '{16'h000a, SET_NONE, SRC_NONE, SRC_NONE, SRC_NONE, 2'h0, 1'b0};
        rows[11] = '{16'h003f, SET_NONE, SRC_NONE, SRC_NONE, SRC_NONE, 2'h0, 1'b0};
        rows[12] = '{16'h0030, SET_ALIGNED, SRC_X1, SRC_Y1, SRC_NONE, 2'h2, 1'b1};
        rows[13] = '{16'h7f00, SET_ALIGNED, SRC_X1, SRC_Y1, SRC_NONE, 2'h2, 1'b1};
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        @(negedge hclk);
        chk32("hreadyout", 32'h1, {31'h0, hreadyout});
        chk32("hresp", 32'h0, {31'h0, hresp});
        chk32("hrdata", 32'h0, hrdata);
        chk32("cfg_locked", 32'h0, {31'h0, cfg_locked});
        chk_dec('0);
        chk32("signal_path_setup", 32'h0, {16'h0, signal_path_setup});
        @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk_dec('0);
        @(negedge hclk);
        chk_dec(exp_row(rows[0]));
        for (int i = 0; i < 14; i++) begin
            wr(`FCD_OFS_FRONT, {16'h0, rows[i].w});
            e = exp_row(rows[i]);
            chk_dec(e);
            rd(`FCD_OFS_FRONT, q);
            chk32("frontend_setup", {16'h0, rows[i].w}, q);
            rd(`FCD_OFS_STATUS, q);
            chk32("status", {30'h0, e.valid, 1'b0}, q);
        end
        wr(`FCD_OFS_SIGNAL, 32'hffffa5c3);
        rd(`FCD_OFS_SIGNAL, q);
        chk32("signal_path_setup", 32'h0000a5c3, q);
        chk32("signal_path_port", 32'h0000a5c3, {16'h0, signal_path_setup});
        wr(`FCD_OFS_OUTPUT, 32'h00003c5a);
        chk32("output_setup", 32'h00003c5a, {16'h0, output_setup});
        rd(`FCD_OFS_OUTPUT, q);
        chk32("output_setup", 32'h00003c5a, q);
        // unmapped place reads zero, write leaves the words alone
        wr(32'h00000010, 32'h0000ffff);
        rd(32'h00000010, q);
        chk32("unmapped", 32'h0, q);
        rd(`FCD_OFS_FRONT, q);
        chk32("frontend_setup", 32'h00007f00, q);
        // lock, then refused writes and sticky status
        wr(`FCD_OFS_FRONT, 32'h00008025);
        chk32("cfg_locked", 32'h1, {31'h0, cfg_locked});
        wr(`FCD_OFS_FRONT, 32'h00000000);
        wr(`FCD_OFS_SIGNAL, 32'h00001111);
        rd(`FCD_OFS_FRONT, q);
        chk32("frontend_setup", 32'h00008025, q);
        chk32("signal_path_port", 32'h0000a5c3, {16'h0, signal_path_setup});
        rd(`FCD_OFS_STATUS, q);
        chk32("status", 32'h7, q);
        wr(`FCD_OFS_STATUS, 32'h4);
        rd(`FCD_OFS_STATUS, q);
        chk32("status", 32'h3, q);
        // only a reset unlocks
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk32("cfg_locked", 32'h0, {31'h0, cfg_locked});
        @(posedge hclk);
        hresetn <= 1'b1;
        rd(`FCD_OFS_FRONT, q);
        chk32("frontend_setup", 32'h0, q);
        finish_test();
    end
endmodule : tb
